// File: rtl/cle_pkg.sv
`default_nettype none

package cle_pkg;

    // Execution times and their cycle counts at the system clock rate
    localparam int CLK_PERIOD_NS = 25;
    localparam int INSTR_TIME_NS = 39000;
    localparam int DATA_TIME_NS = 43000;
    localparam logic [10:0] INSTR_CYC =
        11'((INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [10:0] DATA_CYC =
        11'((DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Memory sizes
    localparam int CHAR_AW = 7;
    localparam int GLYPH_AW = 6;

    // Character RAM address ranges
    localparam logic [6:0] LINE1_END = 7'h27;
    localparam logic [6:0] LINE2_START = 7'h40;
    localparam logic [6:0] LINE2_END = 7'h67;
    localparam logic [6:0] ONE_LINE_END = 7'h4F;
    localparam logic [6:0] LEN_TWO = 7'h28;
    localparam logic [6:0] LEN_ONE = 7'h50;

    // Instruction class bits, highest set bit wins
    localparam int OP_CHAR_ADDR = 7;
    localparam int OP_GLYPH_ADDR = 6;
    localparam int OP_FUNC = 5;
    localparam int OP_SHIFT = 4;
    localparam int OP_DISP = 3;

    // Field positions
    localparam int FUNC_WIDTH = 4;
    localparam int FUNC_LINES = 3;
    localparam int FUNC_FONT = 2;
    localparam int SHIFT_WHOLE = 3;
    localparam int SHIFT_RIGHT = 2;
    localparam int DISP_ON = 2;
    localparam int DISP_CURSOR = 1;
    localparam int DISP_BLINK = 0;
    localparam int BUSY_BIT = 7;

    // Reset values
    localparam logic RST_BUS8 = 1'b1;
    localparam logic RST_TWO_LINE = 1'b0;
    localparam logic RST_FONT = 1'b0;
    localparam logic RST_DISP = 1'b0;
    localparam logic RST_CURSOR = 1'b0;
    localparam logic RST_BLINK = 1'b0;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

endpackage

`default_nettype wire

// File: rtl/cle_ram.sv
`default_nettype none

module cle_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk_sys_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // Registered read port
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);

    // No reset on the array: contents are undefined until written
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk_sys_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule // cle_ram

`default_nettype wire

// File: rtl/cle_engine.sv
// Summary of operation
// - Display-on bit lights or blanks, RAM kept
// - Cursor-on bit shows cursor, direction kept
// - Blink alternates full block and character
// - Cursor shift steps pointer by one
// - Whole shift moves display, data untouched
// - Display shift leaves pointer unchanged
// - Two-line cursor wraps into second line
// - One shift offset serves all lines
// - Width bit selects 8-bit or two nibbles
// - Line bit selects one or two lines
// - Font bit selects 5x8 or 5x11
// - Glyph address set loads six bits
// - Character address set loads seven bits
// - Character addresses wrap within line ranges
// - Status read returns busy and pointer
// - Data write stores byte in selected RAM
// - Pointer steps after each write
// - First read without address set or character cursor shift invalid
// - Cursor shift refetches character RAM byte
// - Pointer steps after each read
// - Read after write returns stale latch
// - Display shift after glyph read unreliable
// - Display control decoded, three low bits
// - Direction high increments pointer
`default_nettype none

module cle_engine #(
    parameter int BLINK_CYCLES = 16000000
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Host bus
    input wire logic target_select_line_i,
    input wire logic read_write_i,
    input wire logic enable_i,
    input wire logic [7:0] bus_line_i,
    output logic [7:0] bus_line_o,
    output logic [7:0] bus_line_oe_o,
    // Entry direction, held outside this block
    input wire logic entry_inc_i,
    // Display state
    output logic display_on_o,
    output logic cursor_on_o,
    output logic blink_on_o,
    output logic cursor_fill_o,
    output logic bus_width_sel_o,
    output logic two_line_o,
    output logic font_tall_o,
    output logic [6:0] display_shift_o,
    output logic [6:0] ram_pointer_o,
    output logic glyph_sel_o,
    output logic internal_op_flag_o
);

    logic en_d_ff, nxt_en_d;
    logic nib_ff, nxt_nib;
    logic [3:0] hi_ff, nxt_hi;
    logic [10:0] busy_ff, nxt_busy;
    logic [6:0] ptr_ff, nxt_ptr;
    logic op_flag_ff, nxt_op_flag;
    logic glyph_ff, nxt_glyph;
    logic disp_ff, nxt_disp;
    logic cur_ff, nxt_cur;
    logic blink_ff, nxt_blink;
    logic bus8_ff, nxt_bus8;
    logic two_ff, nxt_two;
    logic font_ff, nxt_font;
    logic [6:0] shift_ff, nxt_shift;
    logic [7:0] dout_ff, nxt_dout;
    logic fetch_ff, nxt_fetch;
    logic [7:0] db_o_ff, nxt_db_o;
    logic [7:0] db_oe_ff, nxt_db_oe;
    logic [23:0] bcnt_ff, nxt_bcnt;
    logic bphase_ff, nxt_bphase;
    logic fill_ff, nxt_fill;

    logic strobe, busy, op_done;
    logic [7:0] op_byte, rd_byte, char_rd, glyph_rd;
    logic char_we, glyph_we;
    logic [6:0] line_len;

    // Steps the pointer, keeping it inside the valid address ranges
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic inc,
                                             input logic two, input logic glyph);
        if (glyph)
            return {1'b0, inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
        if (two && inc)
            return (a == cle_pkg::LINE1_END) ? cle_pkg::LINE2_START :
                   (a == cle_pkg::LINE2_END) ? 7'h00 : a + 7'h01;
        if (two)
            return (a == cle_pkg::LINE2_START) ? cle_pkg::LINE1_END :
                   (a == 7'h00) ? cle_pkg::LINE2_END : a - 7'h01;
        if (inc)
            return (a >= cle_pkg::ONE_LINE_END) ? 7'h00 : a + 7'h01;
        return (a == 7'h00) ? cle_pkg::ONE_LINE_END : a - 7'h01;
    endfunction

    cle_ram #(.AW(cle_pkg::CHAR_AW), .DW(8)) u_char_code_ram (
        .clk_sys_i(clk_sys_i),
        .we_i(char_we),
        .waddr_i(ptr_ff),
        .wdata_i(op_byte),
        .raddr_i(nxt_ptr),
        .rdata_o(char_rd)
    );

    cle_ram #(.AW(cle_pkg::GLYPH_AW), .DW(8)) u_glyph_ram (
        .clk_sys_i(clk_sys_i),
        .we_i(glyph_we),
        .waddr_i(ptr_ff[5:0]),
        .wdata_i(op_byte),
        .raddr_i(nxt_ptr[5:0]),
        .rdata_o(glyph_rd)
    );

    always_comb
    begin
        nxt_en_d = enable_i;
        nxt_nib = nib_ff;
        nxt_hi = hi_ff;
        nxt_ptr = ptr_ff;
        nxt_glyph = glyph_ff;
        nxt_disp = disp_ff;
        nxt_cur = cur_ff;
        nxt_blink = blink_ff;
        nxt_bus8 = bus8_ff;
        nxt_two = two_ff;
        nxt_font = font_ff;
        nxt_shift = shift_ff;
        nxt_dout = dout_ff;
        nxt_fetch = 1'b0;
        char_we = 1'b0;
        glyph_we = 1'b0;
        op_done = 1'b0;
        op_byte = bus_line_i;
        busy = (busy_ff != 11'h000);
        nxt_busy = busy ? busy_ff - 11'h001 : 11'h000;
        line_len = two_ff ? cle_pkg::LEN_TWO : cle_pkg::LEN_ONE;
        strobe = en_d_ff & ~enable_i;
        // Latch refills one cycle after the pointer moves
        if (fetch_ff)
        begin
            nxt_dout = glyph_ff ? glyph_rd : char_rd;
        end
        // While busy only status reads are honoured
        if (strobe && (!busy || (!target_select_line_i && read_write_i)))
        begin
            if (bus8_ff)
            begin
                op_done = 1'b1;
            end
            else if (!nib_ff)
            begin
                nxt_nib = 1'b1;
                nxt_hi = bus_line_i[7:4];
            end
            else
            begin
                nxt_nib = 1'b0;
                op_done = 1'b1;
                op_byte = {hi_ff, bus_line_i[7:4]};
            end
        end
        if (op_done)
        begin
            case ({target_select_line_i, read_write_i})
                2'b00:
                begin
                    nxt_busy = cle_pkg::INSTR_CYC;
                    if (op_byte[cle_pkg::OP_CHAR_ADDR])
                    begin
                        nxt_ptr = op_byte[6:0];
                        nxt_glyph = 1'b0;
                        nxt_fetch = 1'b1;
                    end
                    else if (op_byte[cle_pkg::OP_GLYPH_ADDR])
                    begin
                        nxt_ptr = {1'b0, op_byte[5:0]};
                        nxt_glyph = 1'b1;
                        nxt_fetch = 1'b1;
                    end
                    else if (op_byte[cle_pkg::OP_FUNC])
                    begin
                        nxt_bus8 = op_byte[cle_pkg::FUNC_WIDTH];
                        nxt_two = op_byte[cle_pkg::FUNC_LINES];
                        nxt_font = op_byte[cle_pkg::FUNC_FONT];
                    end
                    else if (op_byte[cle_pkg::OP_SHIFT])
                    begin
                        // Follows a glyph read with no guarantee of correctness
                        if (op_byte[cle_pkg::SHIFT_WHOLE])
                        begin
                            // One offset for every line; pointer untouched
                            if (op_byte[cle_pkg::SHIFT_RIGHT])
                                nxt_shift = (shift_ff == 7'h00) ? line_len - 7'h01
                                                                : shift_ff - 7'h01;
                            else
                                nxt_shift = (shift_ff >= line_len - 7'h01) ? 7'h00
                                                                          : shift_ff + 7'h01;
                        end
                        else
                        begin
                            nxt_ptr = step_addr(ptr_ff, op_byte[cle_pkg::SHIFT_RIGHT],
                                               two_ff, glyph_ff);
                            nxt_fetch = ~glyph_ff;
                        end
                    end
                    else if (op_byte[cle_pkg::OP_DISP])
                    begin
                        nxt_disp = op_byte[cle_pkg::DISP_ON];
                        nxt_cur = op_byte[cle_pkg::DISP_CURSOR];
                        nxt_blink = op_byte[cle_pkg::DISP_BLINK];
                    end
                end
                2'b10:
                begin
                    nxt_busy = cle_pkg::DATA_CYC;
                    char_we = ~glyph_ff;
                    glyph_we = glyph_ff;
                    // Latch is not refilled, so the next read sees old data
                    nxt_ptr = step_addr(ptr_ff, entry_inc_i, two_ff, glyph_ff);
                end
                2'b11:
                begin
                    nxt_busy = cle_pkg::DATA_CYC;
                    // Latch holds whatever the last fetch left; may be stale
                    nxt_ptr = step_addr(ptr_ff, entry_inc_i, two_ff, glyph_ff);
                    nxt_fetch = 1'b1;
                end
                default:
                begin
                    nxt_busy = nxt_busy;
                end
            endcase
        end
        // Flag kept in its own flop so the output is registered
        nxt_op_flag = (nxt_busy != 11'h000);
        rd_byte = target_select_line_i ? dout_ff : {busy, ptr_ff};
        nxt_db_o = bus8_ff ? rd_byte : (nib_ff ? {rd_byte[3:0], 4'h0}
                                               : {rd_byte[7:4], 4'h0});
        nxt_db_oe = (enable_i && read_write_i) ? (bus8_ff ? 8'hFF : 8'hF0) : 8'h00;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            en_d_ff <= 1'b0;
            nib_ff <= 1'b0;
            hi_ff <= 4'h0;
            busy_ff <= 11'h000;
            ptr_ff <= cle_pkg::RST_ADDR;
            op_flag_ff <= 1'b0;
            glyph_ff <= 1'b0;
            disp_ff <= cle_pkg::RST_DISP;
            cur_ff <= cle_pkg::RST_CURSOR;
            blink_ff <= cle_pkg::RST_BLINK;
            bus8_ff <= cle_pkg::RST_BUS8;
            two_ff <= cle_pkg::RST_TWO_LINE;
            font_ff <= cle_pkg::RST_FONT;
            shift_ff <= cle_pkg::RST_ADDR;
            dout_ff <= cle_pkg::RST_BYTE;
            fetch_ff <= 1'b0;
            db_o_ff <= cle_pkg::RST_BYTE;
            db_oe_ff <= 8'h00;
        end
        else
        begin
            en_d_ff <= nxt_en_d;
            nib_ff <= nxt_nib;
            hi_ff <= nxt_hi;
            busy_ff <= nxt_busy;
            ptr_ff <= nxt_ptr;
            op_flag_ff <= nxt_op_flag;
            glyph_ff <= nxt_glyph;
            disp_ff <= nxt_disp;
            cur_ff <= nxt_cur;
            blink_ff <= nxt_blink;
            bus8_ff <= nxt_bus8;
            two_ff <= nxt_two;
            font_ff <= nxt_font;
            shift_ff <= nxt_shift;
            dout_ff <= nxt_dout;
            fetch_ff <= nxt_fetch;
            db_o_ff <= nxt_db_o;
            db_oe_ff <= nxt_db_oe;
        end
    end

    // Blink divider: the phase only matters while blink is on
    always_comb
    begin
        nxt_bcnt = bcnt_ff + 24'h000001;
        nxt_bphase = bphase_ff;
        if (bcnt_ff >= 24'(BLINK_CYCLES - 1))
        begin
            nxt_bcnt = 24'h000000;
            nxt_bphase = ~bphase_ff;
        end
        nxt_fill = blink_ff & bphase_ff;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            bcnt_ff <= 24'h000000;
            bphase_ff <= 1'b0;
            fill_ff <= 1'b0;
        end
        else
        begin
            bcnt_ff <= nxt_bcnt;
            bphase_ff <= nxt_bphase;
            fill_ff <= nxt_fill;
        end
    end

    assign bus_line_o = db_o_ff;
    assign bus_line_oe_o = db_oe_ff;
    assign display_on_o = disp_ff;
    assign cursor_on_o = cur_ff;
    assign blink_on_o = blink_ff;
    assign cursor_fill_o = fill_ff;
    assign bus_width_sel_o = bus8_ff;
    assign two_line_o = two_ff;
    assign font_tall_o = font_ff;
    assign display_shift_o = shift_ff;
    assign ram_pointer_o = ptr_ff;
    assign glyph_sel_o = glyph_ff;
    assign internal_op_flag_o = op_flag_ff;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    disp_ctl_a: assert property (
        op_done && !target_select_line_i && !read_write_i && op_byte[7:3] == 5'h01
        |=> disp_ff == $past(op_byte[2]) && cur_ff == $past(op_byte[1])
            && blink_ff == $past(op_byte[0]))
        else $error("display control bits not loaded");
    blink_off_a: assert property (
        !blink_ff |=> !fill_ff)
        else $error("cursor filled with blink off");
    dshift_ptr_a: assert property (
        op_done && !target_select_line_i && !read_write_i && op_byte[7:4] == 4'h1
        && op_byte[3] |=> ptr_ff == $past(ptr_ff))
        else $error("display shift moved the pointer");
    cur_left_a: assert property (
        op_done && !target_select_line_i && !read_write_i && op_byte[7:2] == 6'h04
        && !glyph_ff && ptr_ff != 7'h00 && ptr_ff != cle_pkg::LINE2_START
        |=> ptr_ff == $past(ptr_ff) - 7'h01)
        else $error("cursor left did not decrement");
    wrap_a: assert property (
        op_done && !target_select_line_i && !read_write_i && op_byte[7:2] == 6'h05
        && !glyph_ff && two_ff && ptr_ff == 7'h27 |=> ptr_ff == 7'h40)
        else $error("two-line cursor did not wrap to second line");
    status_a: assert property (
        enable_i && read_write_i && !target_select_line_i && bus8_ff
        |=> bus_line_o == {$past(internal_op_flag_o), $past(ptr_ff)} && bus_line_oe_o == 8'hFF)
        else $error("status read returned wrong value");
    busy_hold_a: assert property (
        op_done && target_select_line_i && !read_write_i |=> internal_op_flag_o [*8])
        else $error("busy flag not held after data write");
    nib_first_a: assert property (
        strobe && !bus8_ff && !nib_ff && !busy |=> nib_ff && hi_ff == $past(bus_line_i[7:4]))
        else $error("upper nibble not captured first");
    glyph_set_a: assert property (
        op_done && !target_select_line_i && !read_write_i && op_byte[7:6] == 2'h1
        |=> glyph_ff && ptr_ff == {1'b0, $past(op_byte[5:0])} && fetch_ff)
        else $error("glyph address set not applied");

endmodule // cle_engine

`default_nettype wire

// File: dv/cle_host_model.sv
`default_nettype none

module cle_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Bus toward the engine
    output logic target_select_line_o,
    output logic read_write_o,
    output logic enable_o,
    output logic [7:0] bus_line_o,
    input wire logic [7:0] dev_line_i,
    input wire logic [7:0] dev_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic drive_en;
    logic [7:0] drive_val;
    logic [7:0] idle_val;
    logic narrow;
    logic [7:0] seen_oe;

    // Released lines show the inverse, so a stale value cannot pass
    assign bus_line_o = (dev_oe_i & dev_line_i) |
        (~dev_oe_i & (drive_en ? drive_val : idle_val));

    initial
    begin
        target_select_line_o = 1'b0;
        read_write_o = 1'b0;
        enable_o = 1'b0;
        drive_en = 1'b0;
        drive_val = 8'h00;
        idle_val = 8'hA5;
        narrow = 1'b0;
        seen_oe = 8'h00;
    end

    task automatic strobe(input logic sel, rw, input logic [7:0] v, output logic [7:0] r);
        target_select_line_o <= sel;
        read_write_o <= rw;
        drive_en <= !rw;
        drive_val <= v;
        enable_o <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        r = bus_line_o;
        seen_oe = dev_oe_i;
        enable_o <= 1'b0;
        @(posedge clk_sys_i);
        drive_en <= 1'b0;
        idle_val <= ~v;
        // Idle edge, so a following strobe never redrives in this step
        @(posedge clk_sys_i);
    endtask

    task automatic xfer(input logic sel, rw, input logic [7:0] v, output logic [7:0] r);
        logic [7:0] hi;
        logic [7:0] lo;
        if (narrow)
        begin
            strobe(sel, rw, {v[7:4], ~v[7:4]}, hi);
            strobe(sel, rw, {v[3:0], ~v[3:0]}, lo);
            r = {hi[7:4], lo[7:4]};
        end
        else
            strobe(sel, rw, v, r);
    endtask

    task automatic op(input logic sel, rw, wt, input logic [7:0] v,
                      output logic [7:0] r, output logic [7:0] stat, output logic ok);
        int n;
        logic [7:0] s;
        xfer(sel, rw, v, r);
        if (!sel && !rw && v[7:5] == 3'b001)
            narrow = !v[4];
        ok = 1'b1;
        stat = 8'h00;
        if (wt)
        begin
            xfer(1'b0, 1'b1, 8'h00, stat);
            s = stat;
            n = 0;
            while (s[7] !== 1'b0 && ok)
            begin
                xfer(1'b0, 1'b1, 8'h00, s);
                n++;
                ok = n < 1000;
            end
        end
    endtask
endmodule // cle_host_model

`default_nettype wire

// File: dv/cle_engine_test.sv
`default_nettype none

module cle_engine_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys_i, reset_n_i, entry_inc_i, sel_line, rd_wr, strobe_en;
    logic [7:0] bus_level, dev_out, dev_oe;
    logic disp_on, cur_on, blink_on, fill, width, two, font, gsel, busy;
    logic [6:0] dshift, ptr;
    int errors, check_count, i;
    logic [7:0] cram [128];
    logic [7:0] gram [64];
    logic [5:0] m_ctl;
    logic [6:0] m_ptr, m_shift;
    logic m_gsel;
    logic [7:0] m_latch;

    cle_engine #(.BLINK_CYCLES(4)) uut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .target_select_line_i(sel_line), .read_write_i(rd_wr), .enable_i(strobe_en),
        .bus_line_i(bus_level), .bus_line_o(dev_out), .bus_line_oe_o(dev_oe),
        .entry_inc_i(entry_inc_i), .display_on_o(disp_on), .cursor_on_o(cur_on),
        .blink_on_o(blink_on), .cursor_fill_o(fill), .bus_width_sel_o(width),
        .two_line_o(two), .font_tall_o(font), .display_shift_o(dshift),
        .ram_pointer_o(ptr), .glyph_sel_o(gsel), .internal_op_flag_o(busy));

    cle_host_model host (
        .clk_sys_i(clk_sys_i), .target_select_line_o(sel_line), .read_write_o(rd_wr),
        .enable_o(strobe_en), .bus_line_o(bus_level), .dev_line_i(dev_out),
        .dev_oe_i(dev_oe));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Lines wrap into each other; glyph space wraps on six bits
    function automatic logic [6:0] stepped(input logic [6:0] a, input logic up);
        if (m_gsel) return {1'b0, 6'(a[5:0] + (up ? 6'h01 : 6'h3F))};
        if (m_ctl[4] && up) return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
        if (m_ctl[4]) return (a == 7'h40) ? 7'h27 : (a == 7'h00) ? 7'h67 : a - 7'h01;
        if (up) return (a == 7'h4F) ? 7'h00 : a + 7'h01;
        return (a == 7'h00) ? 7'h4F : a - 7'h01;
    endfunction

    task automatic ref_op(input logic sel, rw, dir, input logic [7:0] v);
        int len;
        len = m_ctl[4] ? 40 : 80;
        if (sel && rw)
        begin
            m_ptr = stepped(m_ptr, dir);
            m_latch = m_gsel ? gram[m_ptr[5:0]] : cram[m_ptr];
        end
        else if (sel)
        begin
            if (m_gsel) gram[m_ptr[5:0]] = v;
            else cram[m_ptr] = v;
            m_ptr = stepped(m_ptr, dir);
        end
        else if (v[7]) {m_ptr, m_gsel, m_latch} = {v[6:0], 1'b0, cram[v[6:0]]};
        else if (v[6]) {m_ptr, m_gsel, m_latch} = {1'b0, v[5:0], 1'b1, gram[v[5:0]]};
        else if (v[5]) m_ctl[5:3] = v[4:2];
        else if (v[4] && v[3]) m_shift = 7'((int'(m_shift) + (v[2] ? len - 1 : 1)) % len);
        else if (v[4])
        begin
            m_ptr = stepped(m_ptr, v[2]);
            if (!m_gsel) m_latch = cram[m_ptr];
        end
        else if (v[3]) m_ctl[2:0] = v[2:0];
    endtask

    task automatic check_state();
        cmp("control", {2'b00, m_ctl},
            {2'b00, width, two, font, disp_on, cur_on, blink_on});
        cmp("busy flag", 8'h00, {7'h00, busy});
        cmp("pointer", {1'b0, m_ptr}, {1'b0, ptr});
        cmp("shift", {1'b0, m_shift}, {1'b0, dshift});
        cmp("glyph select", {7'h00, m_gsel}, {7'h00, gsel});
    endtask

    task automatic check_blink();
        logic seen;
        seen = 1'b0;
        repeat (40)
        begin
            @(posedge clk_sys_i);
            seen = seen | fill;
        end
        cmp("blink phase", {7'h00, m_ctl[0]}, {7'h00, seen});
    endtask

    task automatic do_op(input logic sel, rw, dir, input logic [7:0] v,
                         input logic upd = 1'b1, input logic wt = 1'b1);
        logic [7:0] r, stat, exp;
        logic ok;
        entry_inc_i <= dir;
        @(posedge clk_sys_i);
        exp = m_latch;
        if (upd) ref_op(sel, rw, dir, v);
        host.op(sel, rw, wt, v, r, stat, ok);
        if (!ok)
        begin
            errors++;
            tally_and_finish();
        end
        if (upd && sel && rw) cmp("read data", exp, r);
        if (wt)
        begin
            cmp("status", {1'b1, m_ptr}, stat);
            cmp("output enable", host.narrow ? 8'hF0 : 8'hFF, host.seen_oe);
            check_state();
        end
    endtask

    initial
    begin
        {errors, check_count} = '0;
        {reset_n_i, entry_inc_i} = 2'b01;
        {m_ctl, m_ptr, m_shift, m_gsel, m_latch} = {6'h20, 7'h00, 7'h00, 1'b0, 8'h00};
        void'($urandom(32'h72EC3E8B));
        repeat (16) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        check_state();
        $display("test reset done");
        for (i = 0; i < 8; i++)
        begin
            do_op(1'b0, 1'b0, 1'b1, 8'h08 | 8'(i));
            check_blink();
        end
        $display("test display control done");
        do_op(1'b0, 1'b0, 1'b1, 8'h3C);
        do_op(1'b0, 1'b0, 1'b1, 8'hA6);
        repeat (3) do_op(1'b1, 1'b0, 1'b1, 8'($urandom));
        repeat (2) do_op(1'b0, 1'b0, 1'b1, 8'h10);
        do_op(1'b0, 1'b0, 1'b1, 8'h14);
        do_op(1'b1, 1'b1, 1'b1, 8'h00);
        do_op(1'b0, 1'b0, 1'b1, 8'h18);
        repeat (2) do_op(1'b0, 1'b0, 1'b1, 8'h1C);
        do_op(1'b0, 1'b0, 1'b1, 8'hA6);
        do_op(1'b1, 1'b0, 1'b0, 8'($urandom));
        do_op(1'b1, 1'b1, 1'b0, 8'h00);
        $display("test cursor and shift done");
        do_op(1'b0, 1'b0, 1'b1, 8'h80);
        repeat (4) do_op(1'b1, 1'b0, 1'b1, 8'($urandom));
        do_op(1'b0, 1'b0, 1'b1, 8'h80);
        repeat (4) do_op(1'b1, 1'b1, 1'b1, 8'h00);
        do_op(1'b0, 1'b0, 1'b1, 8'h7E);
        repeat (3) do_op(1'b1, 1'b0, 1'b1, 8'($urandom));
        do_op(1'b0, 1'b0, 1'b1, 8'h7E);
        repeat (3) do_op(1'b1, 1'b1, 1'b1, 8'h00);
        $display("test data access done");
        do_op(1'b0, 1'b0, 1'b1, 8'h0C, 1'b1, 1'b0);
        do_op(1'b1, 1'b0, 1'b1, 8'h5A, 1'b0, 1'b1);
        $display("test refusal done");
        do_op(1'b0, 1'b0, 1'b1, 8'h28);
        do_op(1'b0, 1'b0, 1'b1, 8'h85);
        repeat (2) do_op(1'b1, 1'b0, 1'b1, 8'($urandom));
        do_op(1'b0, 1'b0, 1'b1, 8'h85);
        repeat (2) do_op(1'b1, 1'b1, 1'b1, 8'h00);
        do_op(1'b0, 1'b0, 1'b1, 8'h30);
        $display("test narrow bus done");
        do_op(1'b0, 1'b0, 1'b1, 8'hCF);
        do_op(1'b1, 1'b0, 1'b1, 8'($urandom));
        do_op(1'b0, 1'b0, 1'b1, 8'h10);
        $display("test one line done");
        tally_and_finish();
    end
endmodule // cle_engine_test

`default_nettype wire
